// [logic/sswd_pkg.sv]
package sswd_pkg;

  // ==========================================================
  // Time base
  localparam int unsigned CLK_MHZ   = 250;
  localparam int unsigned TICK_US   = 1;
  localparam int unsigned TICK_CYC  = CLK_MHZ * TICK_US;
  localparam logic [7:0]  TICK_LAST = 8'(TICK_CYC - 1);

  // ==========================================================
  // Times in microseconds or milliseconds, counted in ticks of TICK_US
  localparam int unsigned T_STARTUP_US = 300;
  localparam int unsigned T_CFG_EVAL_US = 381;
  localparam int unsigned T_WD_SETUP_US = 150;
  localparam int unsigned T_RST_MS      = 200;
  localparam int unsigned T_WD_OPEN_MS  = 1600;
  localparam int unsigned T_WD_PULL_MS  = 200;
  localparam int unsigned T_WD_CAP_MS   = 32;
  localparam logic [31:0] STARTUP_TICKS = 32'(T_STARTUP_US / TICK_US);
  localparam logic [31:0] CFG_TICKS     = 32'(T_CFG_EVAL_US / TICK_US);
  localparam logic [31:0] SETUP_TICKS   = 32'(T_WD_SETUP_US / TICK_US);
  localparam logic [31:0] RST_TICKS_DEF = 32'(T_RST_MS * 1000 / TICK_US);
  localparam logic [31:0] WD_OPEN_DEF   = 32'(T_WD_OPEN_MS * 1000 / TICK_US);
  localparam logic [31:0] WD_PULL_DEF   = 32'(T_WD_PULL_MS * 1000 / TICK_US);
  localparam logic [31:0] WD_CAP_DEF    = 32'(T_WD_CAP_MS * 1000 / TICK_US);

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  STATUS_OFS  = 8'h04;
  localparam logic [7:0]  WDCNT_OFS   = 8'h08;
  localparam logic [31:0] CTRL_RST    = 32'h00000000;
  localparam int unsigned CTRL_SOFT_MR = 0;

  // ==========================================================
  // Timeout configuration pin classes
  typedef enum logic [1:0] {
    CFG_OPEN   = 2'h0,
    CFG_PULLUP = 2'h1,
    CFG_CAP    = 2'h2
  } sswd_cfg_e;

  typedef enum logic [3:0] {
    SUP_START = 4'b0001,
    SUP_HOLD  = 4'b0010,
    SUP_DELAY = 4'b0100,
    SUP_RUN   = 4'b1000
  } sswd_sup_e;

  typedef enum logic [3:0] {
    WD_OFF   = 4'b0001,
    WD_SETUP = 4'b0010,
    WD_RUN   = 4'b0100,
    WD_FAULT = 4'b1000
  } sswd_wd_e;

  typedef struct packed {
    logic      [3:0] wd_state;
    logic      [3:0] sup_state;
    sswd_cfg_e       cfg_class;
    logic            cfg_done;
    logic            strap;
    logic            supply_valid;
    logic            fault_active;
    logic            reset_active;
  } sswd_status_s;

endpackage

// [logic/sswd_top.sv]
// Summary of operation
// - Hold reset for release delay, then release
// - Falling indication resets; rising indication revalidates
// - Reset stays high while supply fine
// - Manual reset low asserts system reset
// - Full release delay after manual reset rises
// - Below lockout level, reset driven low
// - Startup interval before reset follows supply
// - Only kick falling edge restarts timeout
// - Missed kick asserts watchdog fault low
// - Fault lasts exactly the release delay unless reset asserts first
// - Fault asserts only while reset released
// - Fault output released while reset asserted
// - Reset asserted disables watchdog, ignores kicks
// - Watchdog resumes after reset release
// - Strap low disables watchdog and kicks once any fault being shown has ended
// - Kicks ignored 150 us after enabling
// - Config pin classed open, pullup, capacitor
// - Config pin evaluated on each validation
// - Open pin gives 1600 ms timeout
// - Pulled-up pin gives 200 ms timeout
module sswd_top
  import sswd_pkg::*;
#(
  parameter logic [31:0] RST_TICKS  = RST_TICKS_DEF,
  parameter logic [31:0] WD_OPEN_TK = WD_OPEN_DEF,
  parameter logic [31:0] WD_PULL_TK = WD_PULL_DEF,
  parameter logic [31:0] WD_CAP_TK  = WD_CAP_DEF
)(
  // Clock, reset, enable
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        ce_i,
  // Supply indications
  input  wire logic        below_falling_threshold_i,
  input  wire logic        above_rising_hysteresis_i,
  input  wire logic        below_lockout_level_i,
  input  wire logic        supply_min_ok_i,
  // Host side pins
  input  wire logic        manual_reset_in_n_i,
  input  wire logic        watchdog_kick_in_i,
  input  wire logic        watchdog_enable_strap_i,
  input  wire logic [1:0]  timeout_config_pin_i,
  output logic             system_reset_n_o,
  output logic             system_reset_oe_o,
  output logic             watchdog_fault_out_n_o,
  output logic             watchdog_fault_oe_o,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o
);

  // ==========================================================
  // Threshold synchronisers
  logic [1:0] fall_sync_ff;
  logic [1:0] rise_sync_ff;
  logic       fall_below;
  logic       rise_above;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fall_sync_ff <= 2'h3;
      rise_sync_ff <= 2'h0;
    end
    else if (ce_i)
    begin
      fall_sync_ff <= {fall_sync_ff[0], below_falling_threshold_i};
      rise_sync_ff <= {rise_sync_ff[0], above_rising_hysteresis_i};
    end
  end

  assign fall_below = fall_sync_ff[1];
  assign rise_above = rise_sync_ff[1];

  // ==========================================================
  // Prescaler: one tick per microsecond
  logic [7:0] pre_cnt_ff;
  logic       tick;

  assign tick = (pre_cnt_ff == TICK_LAST);

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pre_cnt_ff <= 8'h00;
    else if (ce_i)
      pre_cnt_ff <= tick ? 8'h00 : pre_cnt_ff + 8'h01;
  end

  // ==========================================================
  // Register bus
  logic        ctrl_soft_mr_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] rdata_ff;
  logic        addr_take;
  logic [31:0] rd_mux;
  logic        mr_active;

  sswd_status_s status;

  assign addr_take   = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_ff;

  // ==========================================================
  // Supply supervisor state
  sswd_sup_e   sup_ff;
  sswd_sup_e   nxt_sup;
  logic [31:0] sup_cnt_ff;
  logic [31:0] nxt_sup_cnt;
  logic        valid_ff;
  logic        reset_active;
  logic        go_hold;

  // Software may pull reset just like the pin; the two are ORed
  assign mr_active    = !manual_reset_in_n_i || ctrl_soft_mr_ff;
  assign reset_active = (sup_ff != SUP_RUN);
  assign go_hold      = fall_below || below_lockout_level_i
                        || mr_active || !valid_ff;

  // Supply valid only after rising indication; lost on falling
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      valid_ff <= 1'b0;
    else if (ce_i)
    begin
      if (fall_below || below_lockout_level_i)
        valid_ff <= 1'b0;
      else if (rise_above)
        valid_ff <= 1'b1;
    end
  end

  always_comb
  begin
    nxt_sup     = sup_ff;
    nxt_sup_cnt = sup_cnt_ff;
    case (sup_ff)
      SUP_START:
      begin
        if (!supply_min_ok_i)
          nxt_sup_cnt = 32'h00000000;
        else if (tick)
        begin
          if (sup_cnt_ff >= STARTUP_TICKS - 32'h00000001)
          begin
            nxt_sup     = SUP_HOLD;
            nxt_sup_cnt = 32'h00000000;
          end
          else
            nxt_sup_cnt = sup_cnt_ff + 32'h00000001;
        end
      end
      SUP_HOLD:
      begin
        nxt_sup_cnt = 32'h00000000;
        if (!go_hold)
          nxt_sup = SUP_DELAY;
      end
      SUP_DELAY:
      begin
        if (go_hold)
        begin
          nxt_sup     = SUP_HOLD;
          nxt_sup_cnt = 32'h00000000;
        end
        else if (tick)
        begin
          if (sup_cnt_ff >= RST_TICKS - 32'h00000001)
          begin
            nxt_sup     = SUP_RUN;
            nxt_sup_cnt = 32'h00000000;
          end
          else
            nxt_sup_cnt = sup_cnt_ff + 32'h00000001;
        end
      end
      SUP_RUN:
      begin
        if (go_hold)
          nxt_sup = SUP_HOLD;
      end
      default:
      begin
        nxt_sup     = SUP_START;
        nxt_sup_cnt = 32'h00000000;
      end
    endcase
    // Losing the minimum supply restarts the power-on interval
    if (!supply_min_ok_i)
    begin
      nxt_sup     = SUP_START;
      nxt_sup_cnt = 32'h00000000;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sup_ff     <= SUP_START;
      sup_cnt_ff <= 32'h00000000;
    end
    else if (ce_i)
    begin
      sup_ff     <= nxt_sup;
      sup_cnt_ff <= nxt_sup_cnt;
    end
  end

  // ==========================================================
  // Timeout configuration evaluation
  logic        valid_d_ff;
  logic [31:0] cfg_cnt_ff;
  logic        cfg_busy_ff;
  logic        cfg_done_ff;
  sswd_cfg_e   cfg_class_ff;
  sswd_cfg_e   pin_class;
  logic [31:0] wd_limit;

  // An unknown code is treated as a capacitor, the user setting
  assign pin_class = (timeout_config_pin_i == 2'h0) ? CFG_OPEN
                   : (timeout_config_pin_i == 2'h1) ? CFG_PULLUP
                   : CFG_CAP;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      valid_d_ff   <= 1'b0;
      cfg_cnt_ff   <= 32'h00000000;
      cfg_busy_ff  <= 1'b0;
      cfg_done_ff  <= 1'b0;
      cfg_class_ff <= CFG_OPEN;
    end
    else if (ce_i)
    begin
      valid_d_ff <= valid_ff;
      if (!valid_ff)
      begin
        cfg_busy_ff <= 1'b0;
        cfg_done_ff <= 1'b0;
      end
      else if (!valid_d_ff)
      begin
        cfg_busy_ff <= 1'b1;
        cfg_done_ff <= 1'b0;
        cfg_cnt_ff  <= 32'h00000000;
      end
      else if (cfg_busy_ff && tick)
      begin
        if (cfg_cnt_ff >= CFG_TICKS - 32'h00000001)
        begin
          cfg_busy_ff  <= 1'b0;
          cfg_done_ff  <= 1'b1;
          cfg_class_ff <= pin_class;
        end
        else
          cfg_cnt_ff <= cfg_cnt_ff + 32'h00000001;
      end
    end
  end

  assign wd_limit = (cfg_class_ff == CFG_OPEN)   ? WD_OPEN_TK
                  : (cfg_class_ff == CFG_PULLUP) ? WD_PULL_TK
                  : WD_CAP_TK;

  // ==========================================================
  // Watchdog
  sswd_wd_e    wd_ff;
  sswd_wd_e    nxt_wd;
  logic [31:0] wd_cnt_ff;
  logic [31:0] nxt_wd_cnt;
  logic        kick_d_ff;
  logic        kick_fall;
  logic        wd_enable;

  assign kick_fall = kick_d_ff && !watchdog_kick_in_i;
  assign wd_enable = watchdog_enable_strap_i && cfg_done_ff;

  always_comb
  begin
    nxt_wd     = wd_ff;
    nxt_wd_cnt = wd_cnt_ff;
    case (wd_ff)
      WD_OFF:
      begin
        nxt_wd_cnt = 32'h00000000;
        if (wd_enable)
          nxt_wd = WD_SETUP;
      end
      WD_SETUP:
      begin
        if (!wd_enable)
          nxt_wd = WD_OFF;
        else if (tick)
        begin
          if (wd_cnt_ff >= SETUP_TICKS - 32'h00000001)
          begin
            nxt_wd     = WD_RUN;
            nxt_wd_cnt = 32'h00000000;
          end
          else
            nxt_wd_cnt = wd_cnt_ff + 32'h00000001;
        end
      end
      WD_RUN:
      begin
        if (!wd_enable)
          nxt_wd = WD_OFF;
        else if (kick_fall)
          nxt_wd_cnt = 32'h00000000;
        else if (tick)
        begin
          if (wd_cnt_ff >= wd_limit - 32'h00000001)
          begin
            nxt_wd     = WD_FAULT;
            nxt_wd_cnt = 32'h00000000;
          end
          else
            nxt_wd_cnt = wd_cnt_ff + 32'h00000001;
        end
      end
      WD_FAULT:
      begin
        // Kicks are ignored while the fault is shown
        if (tick)
        begin
          if (wd_cnt_ff >= RST_TICKS - 32'h00000001)
          begin
            nxt_wd     = WD_RUN;
            nxt_wd_cnt = 32'h00000000;
          end
          else
            nxt_wd_cnt = wd_cnt_ff + 32'h00000001;
        end
      end
      default:
      begin
        nxt_wd     = WD_OFF;
        nxt_wd_cnt = 32'h00000000;
      end
    endcase
    // System reset overrides everything the watchdog does
    if (nxt_sup != SUP_RUN)
    begin
      nxt_wd     = WD_OFF;
      nxt_wd_cnt = 32'h00000000;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wd_ff     <= WD_OFF;
      wd_cnt_ff <= 32'h00000000;
      kick_d_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      wd_ff     <= nxt_wd;
      wd_cnt_ff <= nxt_wd_cnt;
      kick_d_ff <= watchdog_kick_in_i;
    end
  end

  // ==========================================================
  // Open-drain outputs: enable high pulls the pin low
  logic rst_drive_ff;
  logic fault_drive_ff;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_drive_ff   <= 1'b1;
      fault_drive_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      rst_drive_ff   <= (nxt_sup != SUP_RUN);
      fault_drive_ff <= (nxt_wd == WD_FAULT);
    end
  end

  assign system_reset_n_o       = 1'b0;
  assign system_reset_oe_o      = rst_drive_ff;
  assign watchdog_fault_out_n_o = 1'b0;
  assign watchdog_fault_oe_o    = fault_drive_ff;

  // ==========================================================
  // Register access
  assign status.wd_state     = wd_ff;
  assign status.sup_state    = sup_ff;
  assign status.cfg_class    = cfg_class_ff;
  assign status.cfg_done     = cfg_done_ff;
  assign status.strap        = watchdog_enable_strap_i;
  assign status.supply_valid = valid_ff;
  assign status.fault_active = fault_drive_ff;
  assign status.reset_active = reset_active;

  // Unmapped offsets read as zero and ignore writes
  assign rd_mux = (haddr_i[7:0] == CTRL_OFS)
                    ? {31'h00000000, ctrl_soft_mr_ff}
                : (haddr_i[7:0] == STATUS_OFS)
                    ? {17'h00000, status}
                : (haddr_i[7:0] == WDCNT_OFS) ? wd_cnt_ff
                : 32'h00000000;

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_pend_ff      <= 1'b0;
      wr_addr_ff      <= 8'h00;
      rdata_ff        <= 32'h00000000;
      ctrl_soft_mr_ff <= CTRL_RST[CTRL_SOFT_MR];
    end
    else if (ce_i)
    begin
      wr_pend_ff <= addr_take && hwrite_i;
      wr_addr_ff <= haddr_i[7:0];
      if (addr_take && !hwrite_i)
        rdata_ff <= rd_mux;
      if (wr_pend_ff && (wr_addr_ff == CTRL_OFS))
        ctrl_soft_mr_ff <= hwdata_i[CTRL_SOFT_MR];
    end
  end

endmodule

// [tb/sswd_host.sv]
// ====================
// Host kicking the watchdog
module sswd_host
  import sswd_pkg::*;
#(
  parameter int unsigned HALF_CYC = 15 * TICK_CYC
)(
  // Clock and control
  input  wire logic clock_i,
  input  wire logic kick_en_i,
  // Kick pin
  output logic      kick_o
);
  int unsigned cnt_ff = 0;

  initial kick_o = 1'b1;

  // Falls every 30 us, inside the 40 us open-pin timeout of the test; pulses far above 50 ns
  always @(posedge clock_i)
    if (!kick_en_i)
    begin
      cnt_ff <= 0;
      kick_o <= 1'b1;
    end
    else if (cnt_ff == HALF_CYC - 1)
    begin
      cnt_ff <= 0;
      kick_o <= !kick_o;
    end
    else
      cnt_ff <= cnt_ff + 1;
endmodule

// [tb/sswd_top_chk.sv]
// ====================
// Supervisor checker
module sswd_chk
  import sswd_pkg::*;
#(
  parameter logic [31:0] RST_TICKS  = 32'h14,
  parameter logic [31:0] WD_OPEN_TK = 32'h28,
  parameter logic [31:0] WD_PULL_TK = 32'h1E,
  parameter logic [31:0] WD_CAP_TK  = 32'h19
)(
  // Clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // Supply and host pins
  input wire logic below_falling_threshold_i,
  input wire logic below_lockout_level_i,
  input wire logic supply_min_ok_i,
  input wire logic manual_reset_in_n_i,
  input wire logic watchdog_kick_in_i,
  input wire logic watchdog_enable_strap_i,
  // Open-drain enables
  input wire logic system_reset_oe_o,
  input wire logic watchdog_fault_oe_o
);
  localparam logic [31:0] MIN_A  = (WD_OPEN_TK < WD_PULL_TK) ?
                                   WD_OPEN_TK : WD_PULL_TK;
  localparam logic [31:0] MIN_WD = (MIN_A < WD_CAP_TK) ? MIN_A : WD_CAP_TK;
  // Bounds allow one tick of prescaler phase
  localparam logic [31:0] TC     = TICK_CYC;

  logic [31:0] quiet_ff;
  logic [31:0] rel_ff;
  logic [31:0] strap_ff;
  logic [31:0] kick_ff;
  logic [31:0] flt_ff;
  logic        kick_d_ff;
  wire         cause = below_falling_threshold_i | below_lockout_level_i |
                       !manual_reset_in_n_i | !supply_min_ok_i;

  always_ff @(posedge clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      quiet_ff  <= '0;
      rel_ff    <= '0;
      strap_ff  <= '0;
      kick_ff   <= '0;
      flt_ff    <= '0;
      kick_d_ff <= 1'b0;
    end
    else
    begin
      quiet_ff  <= cause ? '0 : quiet_ff + 1;
      rel_ff    <= system_reset_oe_o ? '0 : rel_ff + 1;
      strap_ff  <= watchdog_enable_strap_i ? strap_ff + 1 : '0;
      kick_ff   <= (kick_d_ff && !watchdog_kick_in_i) ? '0 : kick_ff + 1;
      flt_ff    <= watchdog_fault_oe_o ? flt_ff + 1 : '0;
      kick_d_ff <= watchdog_kick_in_i;
    end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  // ====================
  // Assertions
  a_fall_reset:
    assert property (below_falling_threshold_i |-> ##[1:3] system_reset_oe_o)
    else $error("Reset missed falling indication");
  a_lockout_reset:
    assert property (below_lockout_level_i |-> ##1 system_reset_oe_o)
    else $error("Reset missed lockout");
  a_manual_reset:
    assert property (!manual_reset_in_n_i |-> ##1 system_reset_oe_o)
    else $error("Reset missed manual input");
  a_fault_hiz:
    assert property (system_reset_oe_o [*3] |-> !watchdog_fault_oe_o)
    else $error("Fault driven during reset");
  a_fault_when_run:
    assert property ($rose(watchdog_fault_oe_o) |-> !system_reset_oe_o)
    else $error("Fault raised during reset");
  a_fault_length:
    assert property ($fell(watchdog_fault_oe_o) && !system_reset_oe_o |->
      flt_ff >= (RST_TICKS - 1) * TC && flt_ff <= (RST_TICKS + 1) * TC)
    else $error("Fault length wrong");
  a_release_delay:
    assert property ($fell(system_reset_oe_o) |->
      quiet_ff >= (RST_TICKS - 1) * TC)
    else $error("Reset released early");
  a_kick_timeout:
    assert property ($rose(watchdog_fault_oe_o) |->
      kick_ff >= (MIN_WD - 1) * TC)
    else $error("Fault before timeout");
  a_strap_gate:
    assert property ($rose(watchdog_fault_oe_o) |->
      strap_ff >= (SETUP_TICKS + MIN_WD - 1) * TC)
    else $error("Fault inside strap setup");
  a_reset_gate:
    assert property ($rose(watchdog_fault_oe_o) |->
      rel_ff >= (SETUP_TICKS + MIN_WD - 1) * TC)
    else $error("Fault too soon after reset");
endmodule

bind sswd_top sswd_chk #(
  .RST_TICKS  (RST_TICKS),
  .WD_OPEN_TK (WD_OPEN_TK),
  .WD_PULL_TK (WD_PULL_TK),
  .WD_CAP_TK  (WD_CAP_TK)
) i_sswd_chk (
  .clock_i, .arst_n_i, .below_falling_threshold_i, .below_lockout_level_i,
  .supply_min_ok_i, .manual_reset_in_n_i, .watchdog_kick_in_i,
  .watchdog_enable_strap_i, .system_reset_oe_o, .watchdog_fault_oe_o
);

// [tb/tb_supply_supervisor_watchdog.sv]
module tb_supply_supervisor_watchdog
  import sswd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  // ====================
  // Signals
  localparam int unsigned TC = TICK_CYC;
  logic        clock_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        below_falling_threshold_i = 1'b0;
  logic        above_rising_hysteresis_i = 1'b0;
  logic        below_lockout_level_i = 1'b0;
  logic        supply_min_ok_i = 1'b0;
  logic        manual_reset_in_n_i = 1'b1;
  logic        watchdog_enable_strap_i = 1'b1;
  logic        host_en = 1'b0;
  logic        hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [1:0]  htrans_i = 2'h0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic        watchdog_kick_in_i, system_reset_oe_o, watchdog_fault_oe_o;
  logic        hreadyout_o, hresp_o;
  logic        system_reset_n_o, watchdog_fault_out_n_o;
  logic        ce = 1'b1;
  logic [1:0]  cfg_pin = 2'h0;
  int          mismatches = 0, checks_done = 0, cyc = 0;

  always #2 clock_i = ~clock_i;

  // Timeout counts in ticks of 1 us; small values keep the run short
  sswd_top #(
    .RST_TICKS(32'h14), .WD_OPEN_TK(32'h28),
    .WD_PULL_TK(32'h1E), .WD_CAP_TK(32'h19)
  ) i_sswd_top (
    .clock_i, .arst_n_i, .ce_i(ce), .below_falling_threshold_i,
    .above_rising_hysteresis_i, .below_lockout_level_i, .supply_min_ok_i,
    .manual_reset_in_n_i, .watchdog_kick_in_i, .watchdog_enable_strap_i,
    .timeout_config_pin_i(cfg_pin), .system_reset_n_o,
    .system_reset_oe_o, .watchdog_fault_out_n_o, .watchdog_fault_oe_o,
    .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
    .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o
  );

  sswd_host i_sswd_host (
    .clock_i, .kick_en_i(host_en), .kick_o(watchdog_kick_in_i)
  );

  // ====================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  function automatic logic [31:0] rng(int n, int lo, int hi);
    return {31'h0, (n >= lo) && (n <= hi)};
  endfunction

  task automatic tk(input int t);
    repeat (t * TC) @(posedge clock_i);
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h0, a};
    hwrite_i <= wr;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask

  // Cycles until the chosen enable (0 reset, 1 fault) shows val
  task automatic wait_pin(input logic sel, input logic val,
                          input int lim, output int n);
    n = 0;
    while (((sel ? watchdog_fault_oe_o : system_reset_oe_o) !== val)
           && n < lim)
    begin
      @(posedge clock_i);
      n++;
    end
  endtask

  // ====================
  // Scenarios
  task automatic sc_power();
    int n;
    @(posedge clock_i);
    supply_min_ok_i <= 1'b1;
    above_rising_hysteresis_i <= 1'b1;
    tk(299);
    chk(system_reset_oe_o, 32'h1, "early release");
    wait_pin(1'b0, 1'b0, 30 * TC, n);
    chk(rng(n, 19 * TC, 23 * TC), 32'h1, "startup release");
  endtask

  task automatic sc_kick();
    logic [31:0] rd;
    int n;
    n = 0;
    do
    begin
      tk(1);
      ahb(1'b0, STATUS_OFS, '0, rd);
      n++;
    end
    while (rd[14:11] !== 4'h4 && n < 800);
    chk(rd[14:11], 32'h4, "watchdog not running");
    chk(rd[6:4], 32'h1, "config class");
    host_en <= 1'b1;
    tk(150);
    chk(watchdog_fault_oe_o, 32'h0, "fault while kicked");
    @(negedge watchdog_kick_in_i);
    repeat (100) @(posedge clock_i);
    host_en <= 1'b0;
    wait_pin(1'b1, 1'b1, 45 * TC, n);
    chk(rng(n, 39 * TC - 110, 41 * TC), 32'h1, "timeout");
    wait_pin(1'b1, 1'b0, 25 * TC, n);
    chk(rng(n, 19 * TC, 21 * TC), 32'h1, "fault length");
  endtask

  task automatic sc_strap();
    logic [31:0] rd;
    int n;
    watchdog_enable_strap_i <= 1'b0;
    tk(60);
    ahb(1'b0, STATUS_OFS, '0, rd);
    chk(rd[14:11], 32'h1, "watchdog not off");
    chk(watchdog_fault_oe_o, 32'h0, "fault while off");
    watchdog_enable_strap_i <= 1'b1;
    host_en <= 1'b1;
    tk(100);
    host_en <= 1'b0;
    ahb(1'b0, STATUS_OFS, '0, rd);
    chk(rd[14:11], 32'h2, "no setup window");
    wait_pin(1'b1, 1'b1, 100 * TC, n);
    chk(rng(n, 89 * TC, 92 * TC), 32'h1, "kick in setup");
    wait_pin(1'b1, 1'b0, 25 * TC, n);
  endtask

  task automatic sc_manual();
    int n;
    wait_pin(1'b1, 1'b1, 45 * TC, n);
    host_en <= 1'b1;
    manual_reset_in_n_i <= 1'b0;
    tk(2);
    chk(system_reset_oe_o, 32'h1, "manual reset");
    chk(watchdog_fault_oe_o, 32'h0, "fault not released");
    manual_reset_in_n_i <= 1'b1;
    host_en <= 1'b0;
    wait_pin(1'b0, 1'b0, 25 * TC, n);
    chk(rng(n, 19 * TC, 21 * TC + 10), 32'h1, "manual delay");
    wait_pin(1'b1, 1'b1, 200 * TC, n);
    chk(rng(n, 189 * TC, 192 * TC), 32'h1, "resume");
    wait_pin(1'b1, 1'b0, 25 * TC, n);
  endtask

  task automatic sc_regs();
    logic [31:0] rd;
    int n;
    ahb(1'b0, CTRL_OFS, '0, rd);
    chk(rd, CTRL_RST, "ctrl reset value");
    ahb(1'b1, CTRL_OFS, 32'h1, rd);
    ahb(1'b0, CTRL_OFS, '0, rd);
    chk(rd, 32'h1, "ctrl readback");
    chk(system_reset_oe_o, 32'h1, "soft reset");
    chk(system_reset_n_o, 32'h0, "reset pin level");
    chk(watchdog_fault_out_n_o, 32'h0, "fault pin level");
    ahb(1'b1, CTRL_OFS, 32'h0, rd);
    ahb(1'b1, STATUS_OFS, 32'hFFFFFFFF, rd);
    ahb(1'b0, STATUS_OFS, '0, rd);
    chk(rd[1:0], 32'h1, "status flags");
    ahb(1'b0, 8'h0C, '0, rd);
    chk(rd, 32'h0, "unmapped read");
    wait_pin(1'b0, 1'b0, 25 * TC, n);
    chk(rng(n, 18 * TC, 21 * TC), 32'h1, "soft delay");
  endtask

  task automatic sc_uv();
    int n;
    host_en <= 1'b1;
    below_falling_threshold_i <= 1'b1;
    above_rising_hysteresis_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    chk(system_reset_oe_o, 32'h1, "falling");
    above_rising_hysteresis_i <= 1'b1;
    tk(30);
    chk(system_reset_oe_o, 32'h1, "rise during fall");
    below_falling_threshold_i <= 1'b0;
    wait_pin(1'b0, 1'b0, 25 * TC, n);
    chk(rng(n, 19 * TC, 21 * TC + 10), 32'h1, "uv delay");
    tk(50);
    chk(system_reset_oe_o, 32'h0, "reset not quiet");
    below_lockout_level_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk(system_reset_oe_o, 32'h1, "lockout");
    below_lockout_level_i <= 1'b0;
  endtask

  // Low enable freezes the release delay along with everything else
  task automatic sc_ce();
    int n;
    ce <= 1'b0;
    tk(30);
    chk(system_reset_oe_o, 32'h1, "frozen by enable");
    ce <= 1'b1;
    wait_pin(1'b0, 1'b0, 25 * TC, n);
    chk(rng(n, 19 * TC, 21 * TC + 10), 32'h1, "delay after freeze");
  endtask

  // ====================
  // Sequence and verdict
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Fixed startup and evaluation times dominate; ceiling leaves margin
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 600000)
    begin
      mismatches++;
      complete_run();
    end
  end

  initial
  begin
    repeat (12) @(posedge clock_i);
    arst_n_i <= 1'b1;
    sc_power();
    sc_kick();
    sc_strap();
    sc_manual();
    sc_regs();
    sc_uv();
    sc_ce();
    complete_run();
  end
endmodule
